// ===== shared/bo_defs.vh
`ifndef BO_DEFS_VH
`define BO_DEFS_VH

// operation codes on op_code
`define BO_OP_NOP 5'h00
`define BO_OP_IO_BIT_SET 5'h01
`define BO_OP_IO_BIT_CLEAR 5'h02
`define BO_OP_LOGICAL_LEFT_SHIFT 5'h03
`define BO_OP_LOGICAL_RIGHT_SHIFT 5'h04
`define BO_OP_ROTATE_LEFT_CARRY 5'h05
`define BO_OP_ROTATE_RIGHT_CARRY 5'h06
`define BO_OP_ARITHMETIC_RIGHT_SHIFT 5'h07
`define BO_OP_NIBBLE_SWAP 5'h08
`define BO_OP_INDEXED_FLAG_SET 5'h09
`define BO_OP_INDEXED_FLAG_CLEAR 5'h0a
`define BO_OP_BIT_TO_TRANSFER_FLAG 5'h0b
`define BO_OP_TRANSFER_FLAG_TO_BIT 5'h0c
`define BO_OP_REGISTER_COPY 5'h0d
`define BO_OP_REGISTER_PAIR_COPY 5'h0e
`define BO_OP_IMMEDIATE_LOAD 5'h0f
`define BO_OP_INDIRECT_LOAD 5'h10
`define BO_OP_DISPLACED_LOAD 5'h11
`define BO_OP_DIRECT_LOAD 5'h12
`define BO_OP_GLOBAL_IRQ_ON 5'h13
`define BO_OP_GLOBAL_IRQ_OFF 5'h14

// shift unit selects
`define BO_SH_LSL 3'h0
`define BO_SH_LSR 3'h1
`define BO_SH_ROL 3'h2
`define BO_SH_ROR 3'h3
`define BO_SH_ASR 3'h4

// pointer pair select and addressing mode
`define BO_PTR_X 2'h0
`define BO_PTR_Y 2'h1
`define BO_PTR_Z 2'h2
`define BO_MODE_PLAIN 2'h0
`define BO_MODE_POST_INC 2'h1
`define BO_MODE_PRE_DEC 2'h2

// low register index of each pointer pair
`define BO_PTR_X_LO 5'h1a
`define BO_PTR_Y_LO 5'h1c
`define BO_PTR_Z_LO 5'h1e

// status flag bit positions
`define BO_FLAG_C 0
`define BO_FLAG_Z 1
`define BO_FLAG_N 2
`define BO_FLAG_V 3
`define BO_FLAG_S 4
`define BO_FLAG_H 5
`define BO_FLAG_T 6
`define BO_FLAG_I 7
`define BO_FLAGS_RESET 8'h00
`define BO_REG_RESET 8'h00

// fsm states
`define BO_ST_IDLE 2'h0
`define BO_ST_MEM 2'h1
`define BO_ST_IO 2'h2

`endif

// ===== core/bo_shift.v
`timescale 1ns/10ps
`include "bo_defs.vh"

module bo_shift (
  input wire [2:0] sel,
  input wire [7:0] din,
  input wire cin,
  output reg [7:0] dout,
  output reg c_out,
  output wire z_out,
  output wire n_out,
  output wire v_out
);

  // shift and rotate datapath with carry out
  always @* begin
    case (sel)
      `BO_SH_LSL: begin
        dout = {din[6:0], 1'b0};
        c_out = din[7];
      end
      `BO_SH_LSR: begin
        dout = {1'b0, din[7:1]};
        c_out = din[0];
      end
      `BO_SH_ROL: begin
        dout = {din[6:0], cin};
        c_out = din[7];
      end
      `BO_SH_ROR: begin
        dout = {cin, din[7:1]};
        c_out = din[0];
      end
      `BO_SH_ASR: begin
        dout = {din[7], din[7:1]};
        c_out = din[0];
      end
      default: begin
        dout = din;
        c_out = cin;
      end
    endcase
  end

  // result flags, overflow is negative xor carry
  assign z_out = (dout == 8'h00);
  assign n_out = dout[7];
  assign v_out = dout[7] ^ c_out;

endmodule // bo_shift

// ===== core/bo_exec.v
`timescale 1ns/10ps
`include "bo_defs.vh"

// Functional notes
// - setting an I/O bit forces that bit to one, keeps the flags and takes two cycles.
// - clearing an I/O bit forces that bit to zero, keeps the flags and takes two cycles.
// - logical left shift moves bits up, fills bit 0 with zero, updates Z C N V in one cycle.
// - logical right shift moves bits down, fills bit 7 with zero, updates Z C N V in one cycle.
// - rotate left puts old carry in bit 0 and old bit 7 in carry, updating Z N V, one cycle.
// - rotate right puts old carry in bit 7 and old bit 0 in carry, updating Z N V, one cycle.
// - arithmetic right shift moves bits down keeping the sign bit, updates Z C N V in one cycle.
// - nibble swap exchanges the two halves of a register in one cycle with no flag change.
// - flag instructions set or clear exactly one selected status flag in one cycle.
// - setting or clearing the global interrupt flag takes one cycle and touches only that flag.
// - bit store copies one register bit into the transfer flag in one cycle, nothing else.
// - bit load copies the transfer flag into one register bit in one cycle, flags unchanged.
// - post-increment load reads at the pointer then adds one to it, two cycles, no flags.
// - pre-decrement load subtracts one from the pointer then reads there, two cycles, no flags.
// - displaced load uses the second or third pointer plus an offset, pointer kept, two cycles.
// - direct load reads the immediate address into the register in two cycles, no flags.
module bo_exec #(
  parameter ADDR_W = 16,
  parameter IO_ADDR_W = 5
) (
  input wire clock,
  input wire resetn,
  input wire op_valid,
  output wire op_ready,
  input wire [4:0] op_code,
  input wire [4:0] op_rd,
  input wire [4:0] op_rr,
  input wire [2:0] op_bit,
  input wire [1:0] op_ptr,
  input wire [1:0] op_mode,
  input wire [15:0] op_imm,
  output reg op_done,
  output reg [ADDR_W-1:0] dmem_addr,
  output reg dmem_rd,
  input wire [7:0] dmem_rdata,
  output reg [IO_ADDR_W-1:0] io_addr,
  output reg io_rd,
  input wire [7:0] io_rdata,
  output reg io_wr,
  output reg [7:0] io_wdata,
  output reg [7:0] status_flags,
  input wire [4:0] peek_sel,
  output reg [7:0] peek_data
);

  reg [7:0] regs [0:31];
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [4:0] dest_reg;
  reg [2:0] iobit_reg;
  reg ioset_reg;
  reg [2:0] sh_sel;
  reg [4:0] ptr_lo;
  reg [15:0] ptr_val;
  reg [15:0] ptr_upd;
  reg [15:0] ld_addr;
  reg ld_ok;
  reg ptr_wr;
  reg [7:0] flags_next;
  reg wa_en;
  reg [4:0] wa_idx;
  reg [7:0] wa_dat;
  reg wb_en;
  reg [4:0] wb_idx;
  reg [7:0] wb_dat;
  wire [7:0] sh_out;
  wire sh_c;
  wire sh_z;
  wire sh_n;
  wire sh_v;
  wire take;
  wire [7:0] src_d;
  wire [7:0] src_r;
  wire [7:0] pair_lo;
  wire [7:0] pair_hi;
  integer i;

  assign op_ready = (state_reg == `BO_ST_IDLE);
  assign take = op_valid && op_ready;
  assign src_d = regs[op_rd];
  assign src_r = regs[op_rr];
  assign pair_lo = regs[{op_rr[4:1], 1'b0}];
  assign pair_hi = regs[{op_rr[4:1], 1'b1}];

  // shifter select from the opcode
  always @* begin
    case (op_code)
      `BO_OP_LOGICAL_LEFT_SHIFT: sh_sel = `BO_SH_LSL;
      `BO_OP_LOGICAL_RIGHT_SHIFT: sh_sel = `BO_SH_LSR;
      `BO_OP_ROTATE_LEFT_CARRY: sh_sel = `BO_SH_ROL;
      `BO_OP_ROTATE_RIGHT_CARRY: sh_sel = `BO_SH_ROR;
      default: sh_sel = `BO_SH_ASR;
    endcase
  end

  bo_shift u_shift (
    .sel(sh_sel),
    .din(src_d),
    .cin(status_flags[`BO_FLAG_C]),
    .dout(sh_out),
    .c_out(sh_c),
    .z_out(sh_z),
    .n_out(sh_n),
    .v_out(sh_v)
  );

  // pointer pair selection and load address
  always @* begin
    case (op_ptr)
      `BO_PTR_X: ptr_lo = `BO_PTR_X_LO;
      `BO_PTR_Y: ptr_lo = `BO_PTR_Y_LO;
      default: ptr_lo = `BO_PTR_Z_LO;
    endcase
    ptr_val = {regs[ptr_lo + 5'h01], regs[ptr_lo]};
    ptr_upd = ptr_val;
    ptr_wr = 1'b0;
    ld_addr = ptr_val;
    ld_ok = 1'b1;
    case (op_code)
      `BO_OP_INDIRECT_LOAD: begin
        if (op_mode == `BO_MODE_POST_INC) begin
          ptr_upd = ptr_val + 16'h0001;
          ptr_wr = 1'b1;
        end else if (op_mode == `BO_MODE_PRE_DEC) begin
          ptr_upd = ptr_val - 16'h0001;
          ld_addr = ptr_upd;
          ptr_wr = 1'b1;
        end else if (op_mode != `BO_MODE_PLAIN) begin
          ld_ok = 1'b0;
        end
      end
      `BO_OP_DISPLACED_LOAD: begin
        // second or third pair only, pointer kept
        ld_addr = ptr_val + {10'h000, op_imm[5:0]};
        ld_ok = (op_ptr == `BO_PTR_Y) || (op_ptr == `BO_PTR_Z);
      end
      default: begin
        ld_addr = op_imm;
      end
    endcase
  end

  // sequencer: two-cycle ops spend one cycle in a wait state
  always @* begin
    state_next = `BO_ST_IDLE;
    case (state_reg)
      `BO_ST_IDLE: begin
        if (take) begin
          case (op_code)
            `BO_OP_IO_BIT_SET, `BO_OP_IO_BIT_CLEAR: state_next = `BO_ST_IO;
            `BO_OP_INDIRECT_LOAD, `BO_OP_DISPLACED_LOAD: begin
              if (ld_ok) begin
                state_next = `BO_ST_MEM;
              end
            end
            `BO_OP_DIRECT_LOAD: state_next = `BO_ST_MEM;
            default: state_next = `BO_ST_IDLE;
          endcase
        end
      end
      default: state_next = `BO_ST_IDLE;
    endcase
  end

  // control, bus strobes and done pulse
  always @(posedge clock) begin
    if (!resetn) begin
      state_reg <= `BO_ST_IDLE;
      op_done <= 1'b0;
      dmem_rd <= 1'b0;
      dmem_addr <= {ADDR_W{1'b0}};
      io_rd <= 1'b0;
      io_wr <= 1'b0;
      io_addr <= {IO_ADDR_W{1'b0}};
      io_wdata <= 8'h00;
      dest_reg <= 5'h00;
      iobit_reg <= 3'h0;
      ioset_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_done <= 1'b0;
      dmem_rd <= 1'b0;
      io_rd <= 1'b0;
      io_wr <= 1'b0;
      if (state_reg != `BO_ST_IDLE) begin
        op_done <= 1'b1;
      end else if (take && (state_next == `BO_ST_IDLE)) begin
        op_done <= 1'b1;
      end
      if (take && (state_next == `BO_ST_MEM)) begin
        dmem_rd <= 1'b1;
        dmem_addr <= ld_addr[ADDR_W-1:0];
        dest_reg <= op_rd;
      end
      if (take && (state_next == `BO_ST_IO)) begin
        io_rd <= 1'b1;
        io_addr <= op_imm[IO_ADDR_W-1:0];
        iobit_reg <= op_bit;
        ioset_reg <= (op_code == `BO_OP_IO_BIT_SET);
      end
      if (state_reg == `BO_ST_IO) begin
        io_wr <= 1'b1;
        io_wdata <= io_rdata;
        if (ioset_reg) begin
          io_wdata[iobit_reg] <= 1'b1;
        end else begin
          io_wdata[iobit_reg] <= 1'b0;
        end
      end
    end
  end

  // status flag next value from the taken op
  always @* begin
    flags_next = status_flags;
    if (take) begin
      case (op_code)
        `BO_OP_LOGICAL_LEFT_SHIFT, `BO_OP_LOGICAL_RIGHT_SHIFT, `BO_OP_ROTATE_LEFT_CARRY,
        `BO_OP_ROTATE_RIGHT_CARRY, `BO_OP_ARITHMETIC_RIGHT_SHIFT: begin
          flags_next[`BO_FLAG_C] = sh_c;
          flags_next[`BO_FLAG_Z] = sh_z;
          flags_next[`BO_FLAG_N] = sh_n;
          flags_next[`BO_FLAG_V] = sh_v;
        end
        `BO_OP_INDEXED_FLAG_SET: flags_next[op_bit] = 1'b1;
        `BO_OP_INDEXED_FLAG_CLEAR: flags_next[op_bit] = 1'b0;
        `BO_OP_GLOBAL_IRQ_ON: flags_next[`BO_FLAG_I] = 1'b1;
        `BO_OP_GLOBAL_IRQ_OFF: flags_next[`BO_FLAG_I] = 1'b0;
        `BO_OP_BIT_TO_TRANSFER_FLAG: flags_next[`BO_FLAG_T] = src_d[op_bit];
        default: flags_next = status_flags;
      endcase
    end
  end

  // status flag register, written only by instructions
  always @(posedge clock) begin
    if (!resetn) begin
      status_flags <= `BO_FLAGS_RESET;
    end else begin
      status_flags <= flags_next;
    end
  end

  // register file write ports: a for the result byte, b for a second byte
  always @* begin
    wa_en = 1'b0;
    wa_idx = op_rd;
    wa_dat = src_d;
    wb_en = 1'b0;
    wb_idx = ptr_lo + 5'h01;
    wb_dat = ptr_upd[15:8];
    if (state_reg == `BO_ST_MEM) begin
      wa_en = 1'b1;
      wa_idx = dest_reg;
      wa_dat = dmem_rdata;
    end else if (take) begin
      case (op_code)
        `BO_OP_LOGICAL_LEFT_SHIFT, `BO_OP_LOGICAL_RIGHT_SHIFT, `BO_OP_ROTATE_LEFT_CARRY,
        `BO_OP_ROTATE_RIGHT_CARRY, `BO_OP_ARITHMETIC_RIGHT_SHIFT: begin
          wa_en = 1'b1;
          wa_dat = sh_out;
        end
        `BO_OP_NIBBLE_SWAP: begin
          wa_en = 1'b1;
          wa_dat = {src_d[3:0], src_d[7:4]};
        end
        `BO_OP_TRANSFER_FLAG_TO_BIT: begin
          wa_en = 1'b1;
          wa_dat[op_bit] = status_flags[`BO_FLAG_T];
        end
        `BO_OP_REGISTER_COPY: begin
          wa_en = 1'b1;
          wa_dat = src_r;
        end
        // even-aligned pair copy as one unit
        `BO_OP_REGISTER_PAIR_COPY: begin
          wa_en = 1'b1;
          wa_idx = {op_rd[4:1], 1'b0};
          wa_dat = pair_lo;
          wb_en = 1'b1;
          wb_idx = {op_rd[4:1], 1'b1};
          wb_dat = pair_hi;
        end
        `BO_OP_IMMEDIATE_LOAD: begin
          wa_en = 1'b1;
          wa_dat = op_imm[7:0];
        end
        `BO_OP_INDIRECT_LOAD: begin
          // pointer write-back, low byte on a, high on b
          if (ptr_wr) begin
            wa_en = 1'b1;
            wa_idx = ptr_lo;
            wa_dat = ptr_upd[7:0];
            wb_en = 1'b1;
          end
        end
        default: begin
          wa_en = 1'b0;
          wb_en = 1'b0;
        end
      endcase
    end
  end

  // working register file, up to two bytes per cycle
  always @(posedge clock) begin
    if (!resetn) begin
      for (i = 0; i < 32; i = i + 1) begin
        regs[i] <= `BO_REG_RESET;
      end
    end else begin
      if (wa_en) begin
        regs[wa_idx] <= wa_dat;
      end
      if (wb_en) begin
        regs[wb_idx] <= wb_dat;
      end
    end
  end

  // registered view of one working register
  always @(posedge clock) begin
    if (!resetn) begin
      peek_data <= 8'h00;
    end else begin
      peek_data <= regs[peek_sel];
    end
  end

endmodule // bo_exec

// ===== testbench/bo_checker.sv
`timescale 1ns/10ps
// port checks for the exec block
module bo_checker #(parameter ADDR_W = 16) (
  input wire clock,
  input wire resetn,
  input wire op_valid,
  input wire op_ready,
  input wire [4:0] op_code,
  input wire [2:0] op_bit,
  input wire [1:0] op_ptr,
  input wire [1:0] op_mode,
  input wire [15:0] op_imm,
  input wire op_done,
  input wire [ADDR_W-1:0] dmem_addr,
  input wire dmem_rd,
  input wire io_rd,
  input wire [7:0] io_rdata,
  input wire io_wr,
  input wire [7:0] io_wdata,
  input wire [7:0] status_flags
);
  // decoded takes
  wire tk = op_valid && op_ready;
  wire io_op = tk && (op_code == 5'h01 || op_code == 5'h02);
  wire ld_op = tk && ((op_code == 5'h10 && op_mode != 2'h3) || op_code == 5'h12 ||
    (op_code == 5'h11 && (op_ptr == 2'h1 || op_ptr == 2'h2)));
  wire one_op = tk && op_code >= 5'h03 && op_code <= 5'h0f;
  wire keep_op = tk && (op_code == 5'h08 || op_code >= 5'h0c && op_code <= 5'h0f);
  reg set_reg;
  reg [2:0] bit_reg;
  // remember the running io op
  always @(posedge clock) begin
    if (io_op) begin
      set_reg <= (op_code == 5'h01);
      bit_reg <= op_bit;
    end
  end
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!resetn);
  property p_io_seq;
    io_op |=> io_rd && !op_ready ##1 io_wr && op_done && op_ready;
  endproperty
  a_io_seq: assert property (p_io_seq) else $error("io op sequence wrong");
  property p_io_set;
    io_wr && set_reg |-> io_wdata == ($past(io_rdata) | (8'h01 << bit_reg));
  endproperty
  a_io_set: assert property (p_io_set) else $error("io set data wrong");
  property p_io_clr;
    io_wr && !set_reg |-> io_wdata == ($past(io_rdata) & ~(8'h01 << bit_reg));
  endproperty
  a_io_clr: assert property (p_io_clr) else $error("io clear data wrong");
  property p_io_flags;
    io_op |=> $stable(status_flags) [*2];
  endproperty
  a_io_flags: assert property (p_io_flags) else $error("io op changed flags");
  property p_one_cyc;
    one_op |=> op_done && op_ready;
  endproperty
  a_one_cyc: assert property (p_one_cyc) else $error("one cycle op late");
  property p_load;
    ld_op |=> dmem_rd && !op_done && $stable(status_flags) ##1
      op_done && !dmem_rd && $stable(status_flags);
  endproperty
  a_load: assert property (p_load) else $error("load timing wrong");
  property p_direct;
    tk && op_code == 5'h12 |=> dmem_addr == $past(op_imm);
  endproperty
  a_direct: assert property (p_direct) else $error("direct address wrong");
  property p_flag_set;
    tk && op_code == 5'h09 |=> status_flags == ($past(status_flags) | (8'h01 << $past(op_bit)));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag set wrong");
  property p_flag_clr;
    tk && op_code == 5'h0a |=> status_flags == ($past(status_flags) & ~(8'h01 << $past(op_bit)));
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag clear wrong");
  property p_keep;
    keep_op |=> $stable(status_flags);
  endproperty
  a_keep: assert property (p_keep) else $error("flags changed");
  property p_bst;
    tk && op_code == 5'h0b |=> (status_flags & 8'hbf) == ($past(status_flags) & 8'hbf);
  endproperty
  a_bst: assert property (p_bst) else $error("bit store touched flags");
  property p_refused;
    tk && ((op_code == 5'h10 && op_mode == 2'h3) || (op_code == 5'h11 && op_ptr != 2'h1 &&
      op_ptr != 2'h2)) |=> !dmem_rd && op_done && op_ready && $stable(status_flags);
  endproperty
  a_refused: assert property (p_refused) else $error("refused load acted");
endmodule // bo_checker

bind bo_exec bo_checker #(.ADDR_W(ADDR_W)) i_bo_checker (.clock(clock), .resetn(resetn),
  .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code), .op_bit(op_bit),
  .op_ptr(op_ptr), .op_mode(op_mode), .op_imm(op_imm), .op_done(op_done),
  .dmem_addr(dmem_addr), .dmem_rd(dmem_rd), .io_rd(io_rd), .io_rdata(io_rdata),
  .io_wr(io_wr), .io_wdata(io_wdata), .status_flags(status_flags));

// ===== testbench/tb.sv
`timescale 1ns/10ps
// self-checking bench for the exec block
module tb;
  reg clock = 1'b0;
  reg resetn = 1'b0;
  reg op_valid = 1'b0;
  reg [4:0] op_code = 5'h00, op_rd = 5'h00, op_rr = 5'h00, peek_sel = 5'h00;
  reg [2:0] op_bit = 3'h0;
  reg [1:0] op_ptr = 2'h0, op_mode = 2'h0;
  reg [15:0] op_imm = 16'h0000, aux = 16'h0000;
  reg [7:0] iov = 8'h00, mf = 8'h00;
  reg [7:0] m [0:31];
  reg [32:0] q [$];
  reg [31:0] x;
  reg [4:0] c;
  wire op_ready, op_done, dmem_rd, io_rd, io_wr;
  wire [15:0] dmem_addr;
  wire [4:0] io_addr;
  wire [7:0] io_wdata, status_flags, peek_data, dmem_rdata, io_rdata;
  integer n_fail = 0, checks = 0, i;
  function [7:0] mem(input [15:0] a);
    mem = a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  // memory and io answers, inverted when not read
  assign dmem_rdata = dmem_rd ? mem(dmem_addr) : ~mem(dmem_addr);
  assign io_rdata = io_rd ? iov : ~iov;
  bo_exec i_bo_exec (.clock(clock), .resetn(resetn), .op_valid(op_valid),
    .op_ready(op_ready), .op_code(op_code), .op_rd(op_rd), .op_rr(op_rr), .op_bit(op_bit),
    .op_ptr(op_ptr), .op_mode(op_mode), .op_imm(op_imm), .op_done(op_done),
    .dmem_addr(dmem_addr), .dmem_rd(dmem_rd), .dmem_rdata(dmem_rdata), .io_addr(io_addr),
    .io_rd(io_rd), .io_rdata(io_rdata), .io_wr(io_wr), .io_wdata(io_wdata),
    .status_flags(status_flags), .peek_sel(peek_sel), .peek_data(peek_data));
  initial forever #10 clock = ~clock;
  task bad(input string what, input [15:0] e, input [15:0] g);
    begin
      n_fail = n_fail + 1;
      $display("wrong value %0s expected %h seen %h", what, e, g);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // model one op, queue its result and drive it
  task go(input [4:0] cd, input [4:0] d, input [4:0] r, input [2:0] b, input [1:0] p,
    input [1:0] md, input [15:0] k);
    reg [7:0] v, n, io;
    reg [15:0] a, pv;
    reg cn, ok;
    reg [4:0] pl, pk;
    begin
      io = $urandom;
      v = m[d];
      n = v;
      a = 16'h0000;
      cn = 1'b0;
      pk = d;
      ok = !((cd == 5'h10 && md == 2'h3) || (cd == 5'h11 && p == 2'h0));
      pl = (p == 2'h0) ? 5'h1a : (p == 2'h1) ? 5'h1c : 5'h1e;
      pv = {m[pl + 5'h01], m[pl]};
      case (cd)
        5'h01: a = {3'h0, k[4:0], io | (8'h01 << b)};
        5'h02: a = {3'h0, k[4:0], io & ~(8'h01 << b)};
        5'h03: {cn, n} = {v, 1'b0};
        5'h04: {cn, n} = {v[0], 1'b0, v[7:1]};
        5'h05: {cn, n} = {v, mf[0]};
        5'h06: {cn, n} = {v[0], mf[0], v[7:1]};
        5'h07: {cn, n} = {v[0], v[7], v[7:1]};
        5'h08: n = {v[3:0], v[7:4]};
        5'h09: mf[b] = 1'b1;
        5'h0a: mf[b] = 1'b0;
        5'h0b: mf[6] = v[b];
        5'h0c: n[b] = mf[6];
        5'h0d: n = m[r];
        5'h0e: begin
          m[{d[4:1], 1'b0}] = m[{r[4:1], 1'b0}];
          n = m[{r[4:1], 1'b1}];
          pk = {d[4:1], 1'b1};
        end
        5'h0f: n = k[7:0];
        5'h10: a = (md == 2'h2) ? pv - 16'h0001 : pv;
        5'h11: a = pv + {10'h000, k[5:0]};
        5'h12: a = k;
        5'h13: mf[7] = 1'b1;
        5'h14: mf[7] = 1'b0;
        default: n = v;
      endcase
      if (cd >= 5'h03 && cd <= 5'h07)
        mf[3:0] = {n[7] ^ cn, n[7], n == 8'h00, cn};
      if (cd == 5'h10 && ok) begin
        m[pl] = (md == 2'h1) ? pv[7:0] + 8'h01 : a[7:0];
        m[pl + 5'h01] = (md == 2'h1) ? pv[15:8] + {7'h00, &pv[7:0]} : a[15:8];
      end
      if (cd >= 5'h10 && cd <= 5'h12 && ok)
        n = mem(a);
      m[pk] = n;
      q.push_back({cd <= 5'h02 || (cd >= 5'h10 && cd <= 5'h12 && ok), a, mf, n});
      @(posedge clock);
      iov <= io;
      op_code <= cd;
      op_rd <= d;
      op_rr <= r;
      op_bit <= b;
      op_ptr <= p;
      op_mode <= md;
      op_imm <= k;
      peek_sel <= pk;
      op_valid <= 1'b1;
      @(posedge clock);
      op_valid <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask
  // capture the last memory address or io write
  always @(posedge clock) begin
    if (dmem_rd === 1'b1)
      aux <= dmem_addr;
    if (io_wr === 1'b1)
      aux <= {3'h0, io_addr, io_wdata};
  end
  // compare each completed op against the oldest note
  initial begin : watch
    reg [32:0] e;
    forever begin
      @(posedge clock);
      #1;
      if (op_done === 1'b1) begin
        @(posedge clock);
        #1;
        checks = checks + 1;
        if (q.size() == 0)
          bad("spare done", 16'h0000, 16'h0001);
        else begin
          e = q.pop_front();
          if (peek_data !== e[7:0])
            bad("register", e[7:0], peek_data);
          if (status_flags !== e[15:8])
            bad("flags", e[15:8], status_flags);
          if (e[32] && aux !== e[31:16])
            bad("address or io data", e[31:16], aux);
        end
      end
    end
  end
  // watchdog
  initial begin
    #400000;
    n_fail = n_fail + 1;
    wrap_up;
  end
  initial begin
    x = $urandom(32'h9aab);
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    for (i = 0; i < 32; i = i + 1) begin
      x = $urandom;
      go(5'h0f, i[4:0], 5'h00, 3'h0, 2'h0, 2'h0, x[15:0]);
    end
    $display("test fill done");
    for (i = 0; i < 300; i = i + 1) begin
      x = $urandom;
      c = 5'h03 + x[31:28] % 5'h0f;
      c = (c > 5'h0f) ? c + 5'h03 : c;
      go(c, x[4:0], x[9:5], x[12:10], 2'h0, 2'h0, x[27:12]);
    end
    $display("test bit and flag ops done");
    for (i = 0; i < 40; i = i + 1) begin
      x = $urandom;
      go({4'h0, x[31]} + 5'h01, 5'h00, 5'h00, x[2:0], 2'h0, 2'h0, x[23:8]);
    end
    $display("test io bit ops done");
    for (i = 0; i < 120; i = i + 1) begin
      x = $urandom;
      c = 5'h10 + {3'h0, x[1:0] % 2'h3};
      go(c, x[6:2] % 5'h1a, 5'h00, 3'h0, x[9:8] % 2'h3, x[11:10], x[31:16]);
    end
    $display("test loads done");
    checks = checks + 1;
    if (q.size() != 0)
      bad("missing done", 16'h0000, q.size());
    wrap_up;
  end
endmodule // tb
